// file: cafe_pkg.sv
/*
 * Package for the serial control register bank of the sensor front end.
 * Holds register offsets, widths, reset values, frame layout and carrier types.
 * Assumes the block runs on the master clock with all pins synchronous to it.
 */
package cafe_pkg;

	// Width of a serial address and of a serial data word.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 6;
	// Frame length: read flag, address, data.
	localparam int FRAME_BITS = 1 + ADDR_W + DATA_W;
	localparam logic [3:0] FRAME_BITS_C = 4'hf;

	// Register offsets.
	localparam logic [7:0] A_OPMODE_LO = 8'h00;
	localparam logic [7:0] A_OPMODE_HI = 8'h01;
	localparam logic [7:0] A_GAIN_LO = 8'h02;
	localparam logic [7:0] A_GAIN_HI = 8'h03;
	localparam logic [7:0] A_CLAMP_LO = 8'h04;
	localparam logic [7:0] A_CLAMP_HI = 8'h05;
	localparam logic [7:0] A_CTLMODE = 8'h06;
	localparam logic [7:0] A_PIXGAIN0 = 8'h07;
	localparam logic [7:0] A_PIXGAIN1 = 8'h08;
	localparam logic [7:0] A_PIXGAIN2 = 8'h09;
	localparam logic [7:0] A_PIXGAIN3 = 8'h0a;
	localparam logic [7:0] A_INIT_B = 8'h0f;
	localparam logic [7:0] A_OUT_EN = 8'h16;
	localparam logic [7:0] A_LINE_LO = 8'h17;
	localparam logic [7:0] A_LINE_HI = 8'h18;
	localparam logic [7:0] A_BLOCK = 8'h19;
	localparam logic [7:0] A_OUT_PHASE = 8'h1b;
	localparam logic [7:0] A_RESTORE_OFF = 8'h1c;
	localparam logic [7:0] A_SYNC_POL = 8'h1d;
	localparam logic [7:0] A_FIELD = 8'h1e;
	localparam logic [7:0] A_RESYNC = 8'h1f;
	localparam logic [7:0] A_INIT_A = 8'h20;
	localparam logic [7:0] A_READBACK = 8'h21;
	localparam logic [7:0] A_CORE_RUN = 8'h26;

	// Reset values.
	localparam logic [5:0] R_ZERO = 6'h00;
	localparam logic [5:0] R_GAIN_LO = 6'h16;
	localparam logic [3:0] R_GAIN_HI = 4'h2;
	localparam logic [1:0] R_CLAMP_HI = 2'h2;
	localparam logic R_FIELD = 1'b1;

	// Field widths of the double-wide values.
	localparam int OPMODE_W = 8;
	localparam int GAIN_W = 10;
	localparam int CLAMP_W = 8;
	localparam int LINE_W = 12;

	// Received frame as handed from the shifter to the register bank.
	typedef struct packed {
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cafe_frame_t;

	// Active, sync-timed control values seen by the front end.
	typedef struct packed {
		logic [OPMODE_W-1:0] opmode;
		logic [GAIN_W-1:0] gain;
		logic [CLAMP_W-1:0] clamp;
		logic [DATA_W-1:0] ctlmode;
		logic [4*DATA_W-1:0] pixgain;
		logic [DATA_W-1:0] out_phase;
		logic restore_off;
	} cafe_afe_t;

endpackage : cafe_pkg

// file: cafe_regbank.sv
/*
 * Serial control register bank: a three-wire write port, shadow and active
 * register copies, serial-load-timed and sync-timed apply, and readback.
 * Assumes serial pins and syncs are synchronous to clk and the serial clock
 * runs well below the master clock, so its edges are seen by sampling.
 */
`timescale 1ns/100ps

// Function
// - Internal mode: device makes horizontal pulses.
// - Apply at load edge or sync edge.
// - Sync-timed by default; listed ones load-timed.
// - Wide value split low six, high rest.
// - Wide value updates after higher half write.
// - Lone low write leaves value unchanged.
// - Lone high write still updates whole value.
// - Operation mode is eight bits at 00/01.
// - Readback bit enables serial register readback.
// - Output bit zero forces outputs inactive.
// - Update line value selects apply line.
// - Block bit stops sync-timed loading.
// - Restore-off bit disables restore during preblank.
// - Sync polarity bit: 0 low, 1 high.
// - Field bit: 0 next odd, 1 even.
// - Resync bit retimes blanking to clock.
// - Core run bit zero holds core reset.
module cafe_regbank #(
	parameter int LINE_W = cafe_pkg::LINE_W
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic serial_load,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	input wire logic vertical_sync,
	input wire logic horizontal_sync,
	input wire logic ext_mode,
	output logic serial_data_out,
	output logic serial_data_oe,
	output cafe_pkg::cafe_afe_t afe_ctl,
	output logic outputs_active,
	output logic sync_high_active,
	output logic next_field_even,
	output logic blank_resync_en,
	output logic timing_core_rst_n,
	output logic internal_pulses_en,
	output logic [LINE_W-1:0] apply_line
);

	// Previous samples of the serial clock, load and the two syncs.
	logic sck_q;
	logic sl_q;
	logic vd_q;
	logic hd_q;
	// Shift register and bit count of the frame being received.
	logic [cafe_pkg::FRAME_BITS-1:0] shift;
	logic [3:0] bit_cnt;
	// Frame length as a count value, declared before the shifter reads it.
	localparam logic [3:0] FRAME_BITS_C = cafe_pkg::FRAME_BITS_C;
	// Frame latched at the serial clock edge that completes it.
	cafe_pkg::cafe_frame_t frame;
	logic frame_done;
	// Shadow copies of sync-timed registers, written straight by the host.
	logic [cafe_pkg::OPMODE_W-1:0] sh_opmode;
	logic [cafe_pkg::GAIN_W-1:0] sh_gain;
	logic [cafe_pkg::CLAMP_W-1:0] sh_clamp;
	logic [5:0] sh_ctlmode;
	logic [23:0] sh_pixgain;
	logic [5:0] sh_out_phase;
	logic sh_restore_off;
	logic sh_out_en;
	logic [LINE_W-1:0] sh_line;
	logic [5:0] init_b;
	logic [5:0] init_a;
	// Pending low halves of the double-wide values, held until the high half.
	logic [5:0] lo_opmode;
	logic [5:0] lo_gain;
	logic [5:0] lo_clamp;
	logic [5:0] lo_line;
	// Load-timed registers.
	logic block_sync;
	logic readback_en;
	// A sync-timed write is waiting, and a vertical edge has been seen.
	logic pending;
	logic vd_armed;
	// Line counter within the field.
	logic [LINE_W-1:0] line_cnt;
	// Readback shift register.
	logic [5:0] rb_shift;

	// Edge detects, with syncs normalised to active-high by the polarity bit.
	logic sck_rise;
	logic sck_fall;
	logic sl_rise;
	logic vd_act;
	logic hd_act;
	logic vd_edge;
	logic hd_edge;
	logic sync_apply;
	assign sck_rise = serial_clock & ~sck_q;
	assign sck_fall = ~serial_clock & sck_q;
	assign sl_rise = serial_load & ~sl_q;
	assign vd_act = vertical_sync ~^ sync_high_active;
	assign hd_act = horizontal_sync ~^ sync_high_active;
	assign vd_edge = vd_act & ~vd_q;
	assign hd_edge = hd_act & ~hd_q;
	// Sync apply: line edge after a vertical edge, on the chosen line, not blocked.
	assign sync_apply = hd_edge & vd_armed & pending & ~block_sync
		& (line_cnt == apply_line);

	// Read one register of the map; unmapped offsets read zero.
	function automatic logic [5:0] rd_reg(input logic [7:0] a);
		unique case (a)
			cafe_pkg::A_OPMODE_LO: rd_reg = sh_opmode[5:0];
			cafe_pkg::A_OPMODE_HI: rd_reg = {4'h0, sh_opmode[7:6]};
			cafe_pkg::A_GAIN_LO: rd_reg = sh_gain[5:0];
			cafe_pkg::A_GAIN_HI: rd_reg = {2'h0, sh_gain[9:6]};
			cafe_pkg::A_CLAMP_LO: rd_reg = sh_clamp[5:0];
			cafe_pkg::A_CLAMP_HI: rd_reg = {4'h0, sh_clamp[7:6]};
			cafe_pkg::A_CTLMODE: rd_reg = sh_ctlmode;
			cafe_pkg::A_PIXGAIN0: rd_reg = sh_pixgain[5:0];
			cafe_pkg::A_PIXGAIN1: rd_reg = sh_pixgain[11:6];
			cafe_pkg::A_PIXGAIN2: rd_reg = sh_pixgain[17:12];
			cafe_pkg::A_PIXGAIN3: rd_reg = sh_pixgain[23:18];
			cafe_pkg::A_INIT_B: rd_reg = init_b;
			cafe_pkg::A_OUT_EN: rd_reg = {5'h00, sh_out_en};
			cafe_pkg::A_LINE_LO: rd_reg = sh_line[5:0];
			cafe_pkg::A_LINE_HI: rd_reg = sh_line[11:6];
			cafe_pkg::A_BLOCK: rd_reg = {5'h00, block_sync};
			cafe_pkg::A_OUT_PHASE: rd_reg = sh_out_phase;
			cafe_pkg::A_RESTORE_OFF: rd_reg = {5'h00, sh_restore_off};
			cafe_pkg::A_SYNC_POL: rd_reg = {5'h00, sync_high_active};
			cafe_pkg::A_FIELD: rd_reg = {5'h00, next_field_even};
			cafe_pkg::A_RESYNC: rd_reg = {5'h00, blank_resync_en};
			cafe_pkg::A_INIT_A: rd_reg = init_a;
			cafe_pkg::A_READBACK: rd_reg = {5'h00, readback_en};
			cafe_pkg::A_CORE_RUN: rd_reg = {5'h00, timing_core_rst_n};
			default: rd_reg = cafe_pkg::R_ZERO;
		endcase
	endfunction : rd_reg

	// Sample the pins once per cycle for edge detection.
	always_ff @(posedge clk) begin
		if (srst) begin
			sck_q <= 1'b0;
			// The load line idles high, so no false rise follows reset.
			sl_q <= 1'b1;
			vd_q <= 1'b0;
			hd_q <= 1'b0;
		end else if (ce) begin
			sck_q <= serial_clock;
			sl_q <= serial_load;
			vd_q <= vd_act;
			hd_q <= hd_act;
		end
	end

	// Shift in a frame on serial clock rises while the load line is low.
	always_ff @(posedge clk) begin
		if (srst) begin
			shift <= '0;
			bit_cnt <= 4'h0;
			frame <= '0;
			frame_done <= 1'b0;
		end else if (ce) begin
			frame_done <= 1'b0;
			if (serial_load) begin
				// Load high idles the link and restarts the frame.
				bit_cnt <= 4'h0;
			end else if (sck_rise) begin
				shift <= {shift[cafe_pkg::FRAME_BITS-2:0], serial_data_in};
				if (bit_cnt == FRAME_BITS_C - 4'h1) begin
					// Last bit: hand over the frame and start the next.
					frame <= {shift[cafe_pkg::FRAME_BITS-2:0], serial_data_in};
					frame_done <= 1'b1;
					bit_cnt <= 4'h0;
				end else begin
					bit_cnt <= bit_cnt + 4'h1;
				end
			end
		end
	end

	// Shadow writes; double-wide low halves wait in a holding register.
	always_ff @(posedge clk) begin
		if (srst) begin
			sh_opmode <= '0;
			sh_gain <= {cafe_pkg::R_GAIN_HI, cafe_pkg::R_GAIN_LO};
			sh_clamp <= {cafe_pkg::R_CLAMP_HI, cafe_pkg::R_ZERO};
			sh_ctlmode <= cafe_pkg::R_ZERO;
			sh_pixgain <= '0;
			sh_out_phase <= cafe_pkg::R_ZERO;
			sh_restore_off <= 1'b0;
			sh_out_en <= 1'b0;
			sh_line <= '0;
			init_a <= cafe_pkg::R_ZERO;
			init_b <= cafe_pkg::R_ZERO;
			lo_opmode <= cafe_pkg::R_ZERO;
			lo_gain <= cafe_pkg::R_ZERO;
			lo_clamp <= cafe_pkg::R_ZERO;
			lo_line <= cafe_pkg::R_ZERO;
		end else if (ce && frame_done && !frame.rd) begin
			unique case (frame.addr)
				// Low halves only park; the wide value is untouched.
				cafe_pkg::A_OPMODE_LO: lo_opmode <= frame.data;
				cafe_pkg::A_GAIN_LO: lo_gain <= frame.data;
				cafe_pkg::A_CLAMP_LO: lo_clamp <= frame.data;
				cafe_pkg::A_LINE_LO: lo_line <= frame.data;
				// High halves commit the whole value with the parked low half.
				cafe_pkg::A_OPMODE_HI: sh_opmode <= {frame.data[1:0], lo_opmode};
				cafe_pkg::A_GAIN_HI: sh_gain <= {frame.data[3:0], lo_gain};
				cafe_pkg::A_CLAMP_HI: sh_clamp <= {frame.data[1:0], lo_clamp};
				cafe_pkg::A_LINE_HI: sh_line <= {frame.data, lo_line};
				cafe_pkg::A_CTLMODE: sh_ctlmode <= frame.data;
				cafe_pkg::A_PIXGAIN0: sh_pixgain[5:0] <= frame.data;
				cafe_pkg::A_PIXGAIN1: sh_pixgain[11:6] <= frame.data;
				cafe_pkg::A_PIXGAIN2: sh_pixgain[17:12] <= frame.data;
				cafe_pkg::A_PIXGAIN3: sh_pixgain[23:18] <= frame.data;
				cafe_pkg::A_INIT_B: init_b <= frame.data;
				cafe_pkg::A_INIT_A: init_a <= frame.data;
				cafe_pkg::A_OUT_EN: sh_out_en <= frame.data[0];
				cafe_pkg::A_OUT_PHASE: sh_out_phase <= frame.data;
				cafe_pkg::A_RESTORE_OFF: sh_restore_off <= frame.data[0];
				// Other offsets are load-timed or unmapped and handled elsewhere.
				default: sh_out_en <= sh_out_en;
			endcase
		end
	end

	// Load-timed registers apply on the serial load rising edge.
	logic [5:0] lt_data;
	logic [7:0] lt_addr;
	logic lt_valid;
	always_ff @(posedge clk) begin
		if (srst) begin
			lt_valid <= 1'b0;
			lt_addr <= '0;
			lt_data <= '0;
			block_sync <= 1'b0;
			readback_en <= 1'b0;
			sync_high_active <= 1'b0;
			next_field_even <= cafe_pkg::R_FIELD;
			blank_resync_en <= 1'b0;
			timing_core_rst_n <= 1'b0;
		end else if (ce) begin
			if (frame_done && !frame.rd) begin
				lt_valid <= 1'b1;
				lt_addr <= frame.addr;
				lt_data <= frame.data;
			end
			if (sl_rise && lt_valid) begin
				lt_valid <= 1'b0;
				unique case (lt_addr)
					cafe_pkg::A_BLOCK: block_sync <= lt_data[0];
					cafe_pkg::A_READBACK: readback_en <= lt_data[0];
					cafe_pkg::A_SYNC_POL: sync_high_active <= lt_data[0];
					cafe_pkg::A_FIELD: next_field_even <= lt_data[0];
					cafe_pkg::A_RESYNC: blank_resync_en <= lt_data[0];
					cafe_pkg::A_CORE_RUN: timing_core_rst_n <= lt_data[0];
					default: lt_valid <= 1'b0;
				endcase
			end
		end
	end

	// Track a waiting sync-timed write and the vertical edge that arms it.
	always_ff @(posedge clk) begin
		if (srst) begin
			pending <= 1'b0;
			vd_armed <= 1'b0;
		end else if (ce) begin
			if (frame_done && !frame.rd) begin
				pending <= 1'b1;
			end else if (sync_apply) begin
				pending <= 1'b0;
			end
			if (vd_edge) begin
				vd_armed <= 1'b1;
			end else if (sync_apply) begin
				vd_armed <= 1'b0;
			end
		end
	end

	// Count lines from each vertical edge.
	always_ff @(posedge clk) begin
		if (srst) begin
			line_cnt <= '0;
		end else if (ce) begin
			if (vd_edge) begin
				line_cnt <= '0;
			end else if (hd_edge && vd_armed) begin
				line_cnt <= line_cnt + 1'b1;
			end
		end
	end

	// Copy shadows into the active set on a sync apply.
	always_ff @(posedge clk) begin
		if (srst) begin
			afe_ctl <= '{opmode: '0,
				gain: {cafe_pkg::R_GAIN_HI, cafe_pkg::R_GAIN_LO},
				clamp: {cafe_pkg::R_CLAMP_HI, cafe_pkg::R_ZERO},
				ctlmode: '0, pixgain: '0, out_phase: '0, restore_off: 1'b0};
			outputs_active <= 1'b0;
			apply_line <= '0;
			internal_pulses_en <= 1'b0;
		end else if (ce) begin
			if (sync_apply) begin
				afe_ctl <= '{opmode: sh_opmode, gain: sh_gain, clamp: sh_clamp,
					ctlmode: sh_ctlmode, pixgain: sh_pixgain,
					out_phase: sh_out_phase, restore_off: sh_restore_off};
				outputs_active <= sh_out_en;
				apply_line <= sh_line;
			end
			// Pulses are made inside only in internal mode with the core running.
			internal_pulses_en <= ~ext_mode & timing_core_rst_n;
		end
	end

	// Readback: a read frame shifts the register out MSB first on clock falls.
	always_ff @(posedge clk) begin
		if (srst) begin
			rb_shift <= '0;
			serial_data_out <= 1'b0;
			serial_data_oe <= 1'b0;
		end else if (ce) begin
			if (frame_done && frame.rd && readback_en) begin
				rb_shift <= rd_reg(frame.addr);
				serial_data_oe <= 1'b1;
			end else if (serial_load) begin
				serial_data_oe <= 1'b0;
			end
			if (sck_fall && serial_data_oe) begin
				serial_data_out <= rb_shift[5];
				rb_shift <= {rb_shift[4:0], 1'b0};
			end
		end
	end

	// A wide value changes only after its high half was written.
	property p_low_holds;
		@(posedge clk) disable iff (srst)
		(ce && frame_done && !frame.rd && frame.addr == cafe_pkg::A_GAIN_LO)
		|=> $stable(sh_gain);
	endproperty
	a_low_holds: assert property (p_low_holds) else $error("low half moved value");

	property p_high_commits;
		@(posedge clk) disable iff (srst)
		(ce && frame_done && !frame.rd && frame.addr == cafe_pkg::A_LINE_HI)
		|=> sh_line == {$past(frame.data), $past(lo_line)};
	endproperty
	a_high_commits: assert property (p_high_commits) else $error("high half bad");

	property p_block;
		@(posedge clk) disable iff (srst)
		block_sync |-> !sync_apply;
	endproperty
	a_block: assert property (p_block) else $error("blocked apply fired");

	property p_apply;
		@(posedge clk) disable iff (srst)
		(ce && sync_apply) |=> afe_ctl.gain == $past(sh_gain) && !pending;
	endproperty
	a_apply: assert property (p_apply) else $error("apply copy wrong");

	property p_load_edge;
		@(posedge clk) disable iff (srst)
		(ce && sl_rise && lt_valid && lt_addr == cafe_pkg::A_CORE_RUN)
		|=> timing_core_rst_n == $past(lt_data[0]);
	endproperty
	a_load_edge: assert property (p_load_edge) else $error("core run not applied");

	property p_field;
		@(posedge clk) disable iff (srst)
		(ce && sl_rise && lt_valid && lt_addr == cafe_pkg::A_FIELD)
		|=> next_field_even == $past(lt_data[0]);
	endproperty
	a_field: assert property (p_field) else $error("field bit not applied");

	property p_out_active;
		@(posedge clk) disable iff (srst)
		(ce && sync_apply) |=> outputs_active == $past(sh_out_en);
	endproperty
	a_out_active: assert property (p_out_active) else $error("output bit wrong");

	property p_rb;
		@(posedge clk) disable iff (srst)
		(ce && frame_done && frame.rd && !readback_en) |=> $stable(rb_shift);
	endproperty
	a_rb: assert property (p_rb) else $error("readback while off");

endmodule : cafe_regbank

// file: cafe_host_model.sv
/*
 * Behavioural model of the host processor on the three-wire serial link.
 * Assumes it shares the master clock with the register bank under test.
 */
`timescale 1ns/100ps

module cafe_host_model (
	input wire logic clk,
	output logic serial_load,
	output logic serial_clock,
	output logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_oe
);

	// The link idles with the frame line high and the serial clock still.
	initial begin
		serial_load = 1'b1;
		serial_clock = 1'b0;
		serial_data_in = 1'b0;
	end

	// One serial bit: data set while the clock is low, four master clocks per bit.
	task automatic bit_cycle(input logic b, output logic s);
		serial_clock = 1'b0;
		serial_data_in = b;
		repeat (2) @(posedge clk);
		#1;
		serial_clock = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		s = serial_data_out;
	endtask : bit_cycle

	// One frame: read flag, address and data, then the readback bits for a read.
	task automatic xfer(input logic rd, input logic [7:0] a, input logic [5:0] d,
		output logic [5:0] q);
		logic [14:0] f;
		logic s;
		f = {rd, a, d};
		q = 6'h00;
		@(posedge clk);
		#1;
		serial_load = 1'b0;
		for (int i = 14; i >= 0; i--) begin
			bit_cycle(f[i], s);
		end
		// Readback bits are taken while the released data line keeps toggling.
		for (int i = 5; i >= 0; i--) begin
			if (rd) begin
				bit_cycle(~serial_data_in, q[i]);
			end
		end
		serial_clock = 1'b0;
		serial_data_in = ~serial_data_in;
		repeat (2) @(posedge clk);
		#1;
		serial_load = 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask : xfer

endmodule : cafe_host_model

// file: ccd_afe_serial_register_bank_test.sv
/*
 * Self-checking testbench of the serial register bank: the scenario tasks
 * drive the host model and the syncs, and each judges the outputs it sees.
 * Assumes cafe_pkg and cafe_host_model are compiled before this file.
 */
`timescale 1ns/100ps

module ccd_afe_serial_register_bank_test;

	logic clk, srst, ce, ext_mode, pol, vertical_sync, horizontal_sync;
	logic serial_load, serial_clock, serial_data_in, serial_data_out, serial_data_oe;
	cafe_pkg::cafe_afe_t afe_ctl;
	logic outputs_active, sync_high_active, next_field_even, blank_resync_en;
	logic timing_core_rst_n, internal_pulses_en;
	logic [11:0] apply_line;
	int err_count = 0;
	int n_compared = 0;

	// The bank under test.
	cafe_regbank dut (.clk(clk), .srst(srst), .ce(ce), .serial_load(serial_load),
		.serial_clock(serial_clock), .serial_data_in(serial_data_in),
		.vertical_sync(vertical_sync), .horizontal_sync(horizontal_sync),
		.ext_mode(ext_mode), .serial_data_out(serial_data_out),
		.serial_data_oe(serial_data_oe), .afe_ctl(afe_ctl),
		.outputs_active(outputs_active), .sync_high_active(sync_high_active),
		.next_field_even(next_field_even), .blank_resync_en(blank_resync_en),
		.timing_core_rst_n(timing_core_rst_n),
		.internal_pulses_en(internal_pulses_en), .apply_line(apply_line));

	// The host on the far side of the serial link.
	cafe_host_model host (.clk(clk), .serial_load(serial_load),
		.serial_clock(serial_clock), .serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe));

	// The master clock, 25 MHz, generated here for both the bank and the host model.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Prints the counts and the verdict and ends the run.
	task automatic print_verdict;
		$display("TB: %0d mismatches in %0d compares", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict

	// Single write frame.
	task automatic wr(input logic [7:0] a, input logic [5:0] d);
		logic [5:0] x;
		host.xfer(1'b0, a, d, x);
	endtask : wr

	// Double-wide write, lower location first, both halves always.
	task automatic wide(input logic [7:0] a, input logic [11:0] v);
		wr(a, v[5:0]);
		wr(a + 8'h01, v[11:6]);
	endtask : wide

	// Read frame with a check of the returned word.
	task automatic rd_chk(input logic [7:0] a, input logic [5:0] exp);
		logic [5:0] x;
		host.xfer(1'b1, a, 6'h00, x);
		chk("readback", 32'(exp), 32'(x));
	endtask : rd_chk

	// One sync pulse: into the active level, then back to idle.
	task automatic edge_of(input logic v);
		@(posedge clk);
		#1;
		vertical_sync = v ? pol : vertical_sync;
		horizontal_sync = v ? horizontal_sync : pol;
		repeat (2) @(posedge clk);
		#1;
		vertical_sync = v ? ~pol : vertical_sync;
		horizontal_sync = v ? horizontal_sync : ~pol;
		repeat (2) @(posedge clk);
		#1;
	endtask : edge_of

	// A vertical edge followed by the first horizontal edge of the field.
	task automatic vh;
		edge_of(1'b1);
		edge_of(1'b0);
	endtask : vh

	// Values straight after reset.
	task automatic t_reset;
		chk("gain", 32'h096, 32'(afe_ctl.gain));
		chk("clamp", 32'h080, 32'(afe_ctl.clamp));
		chk("opmode", 32'h000, 32'(afe_ctl.opmode));
		chk("field", 32'h001, 32'(next_field_even));
		chk("core_rst_n", 32'h000, 32'(timing_core_rst_n));
		chk("outputs", 32'h000, 32'(outputs_active));
	endtask : t_reset

	// Load-timed bits take effect at the end of their own frame.
	task automatic t_load;
		wr(8'h0f, 6'h04);
		wr(8'h20, 6'h35);
		wr(8'h26, 6'h01);
		chk("core_rst_n", 32'h001, 32'(timing_core_rst_n));
		@(posedge clk);
		#1;
		chk("int_pulses", 32'h001, 32'(internal_pulses_en));
		ext_mode = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("int_pulses", 32'h000, 32'(internal_pulses_en));
		ext_mode = 1'b0;
		wr(8'h1e, 6'h00);
		chk("field", 32'h000, 32'(next_field_even));
		wr(8'h1f, 6'h01);
		chk("resync", 32'h001, 32'(blank_resync_en));
	endtask : t_load

	// Sync-timed values wait for a horizontal edge after a vertical edge.
	task automatic t_sync;
		wide(8'h02, 12'h2c7);
		wide(8'h00, 12'h0c5);
		wr(8'h1c, 6'h01);
		wr(8'h16, 6'h01);
		chk("gain", 32'h096, 32'(afe_ctl.gain));
		edge_of(1'b1);
		chk("gain", 32'h096, 32'(afe_ctl.gain));
		edge_of(1'b0);
		chk("gain", 32'h2c7, 32'(afe_ctl.gain));
		chk("opmode", 32'h0c5, 32'(afe_ctl.opmode));
		chk("restore_off", 32'h001, 32'(afe_ctl.restore_off));
		chk("outputs", 32'h001, 32'(outputs_active));
	endtask : t_sync

	// A lone lower half is parked; a lone upper half applies with it.
	task automatic t_half;
		wr(8'h04, 6'h2a);
		vh();
		chk("clamp", 32'h080, 32'(afe_ctl.clamp));
		wr(8'h05, 6'h01);
		vh();
		chk("clamp", 32'h06a, 32'(afe_ctl.clamp));
	endtask : t_half

	// The block bit holds sync-timed values until it is cleared.
	task automatic t_block;
		wr(8'h19, 6'h01);
		wr(8'h06, 6'h15);
		vh();
		chk("ctlmode", 32'h000, 32'(afe_ctl.ctlmode));
		wr(8'h19, 6'h00);
		vh();
		chk("ctlmode", 32'h015, 32'(afe_ctl.ctlmode));
	endtask : t_block

	// With line two selected, only the third horizontal edge applies.
	task automatic t_line;
		wide(8'h17, 12'h002);
		vh();
		chk("apply_line", 32'h002, 32'(apply_line));
		wr(8'h1b, 6'h33);
		vh();
		edge_of(1'b0);
		chk("out_phase", 32'h000, 32'(afe_ctl.out_phase));
		edge_of(1'b0);
		chk("out_phase", 32'h033, 32'(afe_ctl.out_phase));
	endtask : t_line

	// Readback of written, load-timed and unmapped locations.
	task automatic t_read;
		wr(8'h21, 6'h01);
		rd_chk(8'h1e, 6'h00);
		rd_chk(8'h26, 6'h01);
		rd_chk(8'h06, 6'h15);
		rd_chk(8'h3c, 6'h00);
		chk("oe", 32'h000, 32'(serial_data_oe));
	endtask : t_read

	// High-active syncs still apply a pending value on the selected line.
	task automatic t_pol;
		wr(8'h1d, 6'h01);
		chk("sync_pol", 32'h001, 32'(sync_high_active));
		pol = 1'b1;
		vertical_sync = 1'b0;
		horizontal_sync = 1'b0;
		wr(8'h06, 6'h2e);
		vh();
		edge_of(1'b0);
		edge_of(1'b0);
		chk("ctlmode", 32'h02e, 32'(afe_ctl.ctlmode));
	endtask : t_pol

	// Main sequence: twelve cycles of reset, then the scenarios.
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		ext_mode = 1'b0;
		pol = 1'b0;
		vertical_sync = 1'b1;
		horizontal_sync = 1'b1;
		repeat (12) @(posedge clk);
		#1;
		srst = 1'b0;
		t_reset();
		t_load();
		t_sync();
		t_half();
		t_block();
		t_line();
		t_read();
		t_pol();
		print_verdict();
	end

	// Watchdog well beyond the under two thousand cycles the scenarios need.
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		print_verdict();
	end

endmodule : ccd_afe_serial_register_bank_test
